// ### verilog/usbmc_pkg.sv
/*
 * usbmc_pkg: constants shared by the usb module control device end, its firmware-side
 * controller end, the checker and the bench.
 * assumes a single 10 MHz clock mclk and an asynchronous active-low reset rst_b.
 */
package usbmc_pkg;
    localparam int USBMC_AW = 2;
    localparam int USBMC_DW = 8;
    localparam logic [1:0] USBMC_ADDR_CTRL = 2'h0;
    localparam logic [1:0] USBMC_ADDR_IRQ_STAT = 2'h1;
    localparam logic [1:0] USBMC_ADDR_IRQ_MASK = 2'h2;
    localparam logic [1:0] USBMC_ADDR_STATUS = 2'h3;
    localparam int USBMC_BIT_SUSPEND = 1;
    localparam int USBMC_BIT_RESUME = 2;
    localparam int USBMC_BIT_ENABLE = 3;
    localparam int USBMC_BIT_PACKET_PROCESSING_DISABLE = 4;
    localparam int USBMC_BIT_SE0 = 5;
    localparam int USBMC_BIT_PPRST = 6;
    localparam logic [7:0] USBMC_CTRL_RESET = 8'h00;
    localparam logic [7:0] USBMC_CTRL_WMASK = 8'h4E;
    localparam int USBMC_IRQ_SETUP = 0;
    localparam int USBMC_IRQ_SE0_END = 1;
    localparam int USBMC_IRQ_RESUME_DONE = 2;
    localparam int USBMC_NIRQ = 3;
    localparam int USBMC_CLK_HZ = 10_000_000;
    localparam int USBMC_RESUME_MS = 10;
    localparam int USBMC_RESUME_CYC = USBMC_RESUME_MS * (USBMC_CLK_HZ / 1000);
    localparam int USBMC_NEP = 16;
endpackage : usbmc_pkg

// ### verilog/usbmc_if.sv
/*
 * usbmc_if: control register port between the device control block and its controller.
 * assumes both ends run on mclk; read data are valid the cycle after rd.
 */
`timescale 1ns/1ps
interface usbmc_if;
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    modport dev (input addr, input wdata, input wr, input rd, output rdata);
    modport ctl (output addr, output wdata, output wr, output rd, input rdata);
endinterface : usbmc_if

// ### verilog/usbmc_device.sv
/*
 * usbmc_device: usb module control register and the engine control it steers.
 * assumes the engine, transceiver and descriptor ram sit outside and take these levels.
 */
`timescale 1ns/1ps
module usbmc_device
    import usbmc_pkg::*;
#(
    parameter int NEP = USBMC_NEP
) (
    input wire logic mclk,
    input wire logic rst_b,
    usbmc_if.dev bus,
    input wire logic clk_source_ok,
    input wire logic pullup_cfg,
    input wire logic pingpong_used,
    input wire logic line_se0,
    input wire logic setup_token,
    input wire logic [NEP-1:0] pointer_toggle,
    output logic engine_active,
    output logic engine_clk_en,
    output logic pullup_on,
    output logic resume_drive,
    output logic xcvr_idle,
    output logic packet_halt,
    output logic status_fifo_open,
    output logic [NEP-1:0] descriptor_odd_even_pointer
);
    logic [7:0] usb_module_control;
    logic en_set, pp_force;
    assign en_set = usb_module_control[USBMC_BIT_ENABLE];
    assign pp_force = en_set & usb_module_control[USBMC_BIT_PPRST] & pingpong_used;

    // control register; bits 7,0,5 never stored
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            usb_module_control <= USBMC_CTRL_RESET;
        end else begin
            if (bus.wr && bus.addr == USBMC_ADDR_CTRL) begin
                usb_module_control[USBMC_BIT_PPRST] <= bus.wdata[USBMC_BIT_PPRST];
                usb_module_control[USBMC_BIT_RESUME] <= bus.wdata[USBMC_BIT_RESUME];
                usb_module_control[USBMC_BIT_SUSPEND] <= bus.wdata[USBMC_BIT_SUSPEND];
                usb_module_control[USBMC_BIT_ENABLE] <= bus.wdata[USBMC_BIT_ENABLE] & clk_source_ok;
            end
            // set beats a same-cycle clear
            if (en_set && setup_token) begin
                usb_module_control[USBMC_BIT_PACKET_PROCESSING_DISABLE] <= 1'b1;
            end else if (bus.wr && bus.addr == USBMC_ADDR_CTRL && !bus.wdata[USBMC_BIT_PACKET_PROCESSING_DISABLE]) begin
                usb_module_control[USBMC_BIT_PACKET_PROCESSING_DISABLE] <= 1'b0;
            end
            if (!clk_source_ok) begin
                usb_module_control[USBMC_BIT_ENABLE] <= 1'b0;
            end
        end
    end

    // engine-facing levels, all registered
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            engine_active <= 1'b0;
            engine_clk_en <= 1'b0;
            pullup_on <= 1'b0;
            resume_drive <= 1'b0;
            xcvr_idle <= 1'b1;
            packet_halt <= 1'b0;
            status_fifo_open <= 1'b0;
        end else begin
            engine_active <= en_set;
            engine_clk_en <= en_set & ~usb_module_control[USBMC_BIT_SUSPEND];
            pullup_on <= en_set & pullup_cfg;
            resume_drive <= en_set & usb_module_control[USBMC_BIT_RESUME];
            xcvr_idle <= ~en_set | (usb_module_control[USBMC_BIT_SUSPEND] & ~usb_module_control[USBMC_BIT_RESUME]);
            packet_halt <= en_set & usb_module_control[USBMC_BIT_PACKET_PROCESSING_DISABLE];
            status_fifo_open <= en_set;
        end
    end

    // pointers zeroed on enable rising and while forced to even banks
    logic en_q;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            en_q <= 1'b0;
        end else begin
            en_q <= en_set;
        end
    end
    genvar g;
    generate
        for (g = 0; g < NEP; g++) begin : g_ptr
            always_ff @(posedge mclk or negedge rst_b) begin
                if (!rst_b) begin
                    descriptor_odd_even_pointer[g] <= 1'b0;
                end else if ((en_set && !en_q) || pp_force) begin
                    descriptor_odd_even_pointer[g] <= 1'b0;
                end else if (en_set && pingpong_used && pointer_toggle[g]) begin
                    descriptor_odd_even_pointer[g] <= ~descriptor_odd_even_pointer[g];
                end
            end
        end
    endgenerate

    // read port; se0 is sampled live, reserved bits zero
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            bus.rdata <= 8'h00;
        end else if (bus.rd && bus.addr == USBMC_ADDR_CTRL) begin
            bus.rdata <= (usb_module_control & USBMC_CTRL_WMASK) | {2'b00, line_se0, 5'b00000}
                | {3'b000, usb_module_control[USBMC_BIT_PACKET_PROCESSING_DISABLE], 4'h0};
        end else begin
            bus.rdata <= 8'h00;
        end
    end
endmodule : usbmc_device

// ### verilog/usbmc_ctrl.sv
/*
 * usbmc_ctrl: firmware-side controller driving the control register over the interface.
 * assumes software reaches it by a plain strobe port; rdata valid one cycle after rd.
 */
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ps
module usbmc_ctrl
    import usbmc_pkg::*;
#(
    parameter int RESUME_CYC = USBMC_RESUME_CYC
) (
    input wire logic mclk,
    input wire logic rst_b,
    usbmc_if.ctl bus,
    input wire logic [1:0] sw_addr,
    input wire logic [7:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [7:0] sw_rdata,
    output logic irq
);
    typedef enum logic [3:0] {
        USBMC_IDLE = 4'h1, USBMC_WRITE = 4'h2, USBMC_POLL = 4'h4, USBMC_WAIT = 4'h8
    } usbmc_state_t;
    usbmc_state_t state;
    logic [7:0] shadow, last_rd;
    logic [USBMC_NIRQ-1:0] irq_stat, irq_mask;
    logic [23:0] resume_cnt;
    logic se0_seen, pending_wr, poll_ret;
    logic [7:0] pending_val;

    // software writes queue one control write; resume bit is timed here
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state <= USBMC_IDLE;
            bus.addr <= USBMC_ADDR_CTRL;
            bus.wdata <= 8'h00;
            bus.wr <= 1'b0;
            bus.rd <= 1'b0;
            shadow <= USBMC_CTRL_RESET;
            resume_cnt <= 24'h000000;
            pending_wr <= 1'b0;
            pending_val <= 8'h00;
        end else begin
            bus.wr <= 1'b0;
            bus.rd <= 1'b0;
            case (state)
                USBMC_IDLE: begin
                    if (pending_wr) begin
                        pending_wr <= 1'b0;
                        shadow <= pending_val;
                        bus.wdata <= pending_val;
                        bus.wr <= 1'b1;
                        if (pending_val[USBMC_BIT_RESUME]) begin
                            resume_cnt <= 24'(RESUME_CYC);
                        end
                        state <= USBMC_WRITE;
                    end else if (resume_cnt == 24'h000001) begin
                        shadow[USBMC_BIT_RESUME] <= 1'b0;
                        bus.wdata <= (shadow & 8'hFB) | 8'h10;
                        bus.wr <= 1'b1;
                        resume_cnt <= 24'h000000;
                        state <= USBMC_WRITE;
                    end else begin
                        bus.rd <= 1'b1;
                        state <= USBMC_POLL;
                    end
                end
                USBMC_WRITE: state <= USBMC_IDLE;
                USBMC_POLL: state <= USBMC_WAIT;
                USBMC_WAIT: state <= USBMC_IDLE;
                default: state <= USBMC_IDLE;
            endcase
            // after the case so a write arriving as the last one is sent is not lost
            if (sw_wr && sw_addr == USBMC_ADDR_CTRL) begin
                pending_wr <= 1'b1;
                pending_val <= sw_wdata;
            end
            if (resume_cnt > 24'h000001) begin
                resume_cnt <= resume_cnt - 24'h000001;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            last_rd <= 8'h00;
            se0_seen <= 1'b0;
            poll_ret <= 1'b0;
        end else begin
            poll_ret <= (state == USBMC_POLL);
            if (poll_ret) begin
                last_rd <= bus.rdata;
                se0_seen <= bus.rdata[USBMC_BIT_SE0];
            end
        end
    end

    // sticky events, write one to clear, set wins
    logic [USBMC_NIRQ-1:0] ev;
    assign ev[USBMC_IRQ_SETUP] = poll_ret & bus.rdata[USBMC_BIT_PACKET_PROCESSING_DISABLE] & ~last_rd[USBMC_BIT_PACKET_PROCESSING_DISABLE];
    assign ev[USBMC_IRQ_SE0_END] = poll_ret & se0_seen & ~bus.rdata[USBMC_BIT_SE0];
    assign ev[USBMC_IRQ_RESUME_DONE] = (state == USBMC_IDLE) && resume_cnt == 24'h000001 && !pending_wr;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            irq_stat <= '0;
            irq_mask <= '0;
            irq <= 1'b0;
        end else begin
            irq_stat <= (irq_stat & ~((sw_wr && sw_addr == USBMC_ADDR_IRQ_STAT)
                ? sw_wdata[USBMC_NIRQ-1:0] : '0)) | ev;
            if (sw_wr && sw_addr == USBMC_ADDR_IRQ_MASK) begin
                irq_mask <= sw_wdata[USBMC_NIRQ-1:0];
            end
            irq <= |(irq_stat & irq_mask);
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sw_rdata <= 8'h00;
        end else if (sw_rd) begin
            case (sw_addr)
                USBMC_ADDR_CTRL: sw_rdata <= shadow;
                USBMC_ADDR_IRQ_STAT: sw_rdata <= {5'b00000, irq_stat};
                USBMC_ADDR_IRQ_MASK: sw_rdata <= {5'b00000, irq_mask};
                USBMC_ADDR_STATUS: sw_rdata <= last_rd;
                default: sw_rdata <= 8'h00;
            endcase
        end else begin
            sw_rdata <= 8'h00;
        end
    end
endmodule : usbmc_ctrl

// ### testbench/usbmc_props.sv
/* usbmc_props: assertions on the joined register port and the device pins.
   assumes one clock mclk and reset rst_b, async low; instantiated by the bench. */
`timescale 1ns/1ps
module usbmc_props
    import usbmc_pkg::*;
#(
    parameter int NEP = USBMC_NEP
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic clk_source_ok,
    input wire logic pullup_cfg,
    input wire logic line_se0,
    input wire logic setup_token,
    input wire logic engine_active,
    input wire logic engine_clk_en,
    input wire logic pullup_on,
    input wire logic resume_drive,
    input wire logic xcvr_idle,
    input wire logic packet_halt,
    input wire logic [NEP-1:0] descriptor_odd_even_pointer
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence seq_en_write;
        wr && addr == USBMC_ADDR_CTRL && wdata[USBMC_BIT_ENABLE] && clk_source_ok;
    endsequence
    sequence seq_setup_seen;
        setup_token ##1 engine_active ##1 engine_active;
    endsequence
    chk_bits_zero: assert property (rd |=> !rdata[7] && !rdata[0])
        else $error("unused control bits read nonzero");
    chk_se0_live: assert property (rd |=> rdata[USBMC_BIT_SE0] == $past(line_se0))
        else $error("line state bit not live");
    chk_en_refused: assert property (!clk_source_ok |-> ##2 !engine_active)
        else $error("engine active without clock source");
    chk_en_sets: assert property (seq_en_write |-> ##2 engine_active)
        else $error("enable write did not activate engine");
    chk_ptr_clear: assert property ($rose(engine_active) |-> descriptor_odd_even_pointer == '0)
        else $error("pointers not cleared on enable");
    chk_pullup_follow: assert property (pullup_on == (engine_active && $past(pullup_cfg)))
        else $error("pull-up does not follow enable");
    chk_off_quiet: assert property (!engine_active |-> xcvr_idle && !engine_clk_en && !resume_drive)
        else $error("control bits act while disabled");
    chk_susp_idle: assert property (engine_active && !engine_clk_en && !resume_drive |-> xcvr_idle)
        else $error("transceiver not idle in suspend");
    chk_setup_halt: assert property (seq_setup_seen |-> packet_halt)
        else $error("setup token did not halt packets");
    chk_pkt_clear: assert property (wr && addr == USBMC_ADDR_CTRL && !wdata[USBMC_BIT_PACKET_PROCESSING_DISABLE] && !setup_token
        |-> ##2 !packet_halt)
        else $error("packet disable not cleared by write");
endmodule : usbmc_props

// ### testbench/usbmc_bench.sv
/* usbmc_bench: drives the controller's software port and the device's line inputs.
   assumes the package, interface, both ends and the checker are compiled first. */
`timescale 1ns/1ps
module usbmc_bench
    import usbmc_pkg::*;
;
    localparam int RC = 20;
    localparam int NEP = USBMC_NEP;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [1:0] sw_addr = 2'h0;
    logic [7:0] sw_wdata = 8'h00;
    logic sw_wr = 1'b0;
    logic sw_rd = 1'b0;
    logic clk_source_ok = 1'b0;
    logic pullup_cfg = 1'b1;
    logic pingpong_used = 1'b1;
    logic line_se0 = 1'b0;
    logic setup_token = 1'b0;
    logic [NEP-1:0] pointer_toggle = '0;
    logic [NEP-1:0] ptr;
    logic [7:0] sw_rdata;
    logic [7:0] rv;
    logic irq, engine_active, engine_clk_en, pullup_on, resume_drive, xcvr_idle, packet_halt, fifo_open;
    int err_total = 0;
    int cmp_count = 0;
    int hi_cnt = 0;
    usbmc_if i_usbmc_if ();
    usbmc_device #(.NEP(NEP)) i_usbmc_device (.mclk(mclk), .rst_b(rst_b), .bus(i_usbmc_if.dev),
        .clk_source_ok(clk_source_ok), .pullup_cfg(pullup_cfg), .pingpong_used(pingpong_used),
        .line_se0(line_se0), .setup_token(setup_token), .pointer_toggle(pointer_toggle),
        .engine_active(engine_active), .engine_clk_en(engine_clk_en), .pullup_on(pullup_on),
        .resume_drive(resume_drive), .xcvr_idle(xcvr_idle), .packet_halt(packet_halt),
        .status_fifo_open(fifo_open), .descriptor_odd_even_pointer(ptr));
    usbmc_ctrl #(.RESUME_CYC(RC)) i_usbmc_ctrl (.mclk(mclk), .rst_b(rst_b), .bus(i_usbmc_if.ctl),
        .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq(irq));
    usbmc_props #(.NEP(NEP)) i_usbmc_props (.mclk(mclk), .rst_b(rst_b), .addr(i_usbmc_if.addr),
        .wdata(i_usbmc_if.wdata), .wr(i_usbmc_if.wr), .rd(i_usbmc_if.rd), .rdata(i_usbmc_if.rdata),
        .clk_source_ok(clk_source_ok), .pullup_cfg(pullup_cfg), .line_se0(line_se0),
        .setup_token(setup_token), .engine_active(engine_active), .engine_clk_en(engine_clk_en),
        .pullup_on(pullup_on), .resume_drive(resume_drive), .xcvr_idle(xcvr_idle),
        .packet_halt(packet_halt), .descriptor_odd_even_pointer(ptr));
    always @(posedge mclk) if (resume_drive === 1'b1) hi_cnt <= hi_cnt + 1;
    task automatic chk1(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %b want %b", $time, got, exp);
        end
    endtask : chk1
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    // settle covers the forward delay of 1-3 cycles plus two for the outputs
    task automatic wr_sw(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge mclk);
        sw_wr <= 1'b0;
        repeat (8) @(posedge mclk);
        #1;
    endtask : wr_sw
    task automatic rd_sw(input logic [1:0] a);
        @(posedge mclk);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge mclk);
        sw_rd <= 1'b0;
        #1 rv = sw_rdata;
    endtask : rd_sw
    task automatic toggle_all();
        @(posedge mclk);
        pointer_toggle <= '1;
        @(posedge mclk);
        pointer_toggle <= '0;
        repeat (2) @(posedge mclk);
        #1;
    endtask : toggle_all
    initial begin
        forever #50 mclk = ~mclk;
    end
    initial begin
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        #1 chk1(xcvr_idle, 1'b1);
        wr_sw(USBMC_ADDR_CTRL, 8'h08);
        chk1(engine_active, 1'b0);
        clk_source_ok <= 1'b1;
        repeat (20000) @(posedge mclk);
        wr_sw(USBMC_ADDR_CTRL, 8'h18);
        chk1(engine_active & ~|ptr, 1'b1);
        chk1(pullup_on, 1'b1);
        chk1(packet_halt, 1'b0);
        toggle_all();
        chk1(&ptr, 1'b1);
        wr_sw(USBMC_ADDR_CTRL, 8'h48);
        toggle_all();
        chk1(|ptr, 1'b0);
        wr_sw(USBMC_ADDR_CTRL, 8'h08);
        toggle_all();
        chk1(&ptr, 1'b1);
        pingpong_used <= 1'b0;
        wr_sw(USBMC_ADDR_CTRL, 8'h48);
        chk1(&ptr, 1'b1);
        line_se0 <= 1'b1;
        wr_sw(USBMC_ADDR_CTRL, 8'h08);
        rd_sw(USBMC_ADDR_STATUS);
        chk1(rv[USBMC_BIT_SE0] & ~rv[7] & ~rv[0], 1'b1);
        line_se0 <= 1'b0;
        wr_sw(USBMC_ADDR_IRQ_MASK, 8'h02);
        chk1(irq, 1'b1);
        wr_sw(USBMC_ADDR_IRQ_STAT, 8'h02);
        chk1(irq, 1'b0);
        setup_token <= 1'b1;
        @(posedge mclk) setup_token <= 1'b0;
        repeat (3) @(posedge mclk);
        #1 chk1(packet_halt & fifo_open, 1'b1);
        wr_sw(USBMC_ADDR_CTRL, 8'h0A);
        chk1(packet_halt, 1'b0);
        chk1(engine_clk_en, 1'b0);
        chk1(xcvr_idle & pullup_on, 1'b1);
        wr_sw(USBMC_ADDR_CTRL, 8'h0E);
        chk1(resume_drive & ~xcvr_idle, 1'b1);
        for (int n = 0; resume_drive === 1'b1; n++) begin
            if (n == 100) begin
                err_total++;
                print_verdict();
            end
            @(posedge mclk);
        end
        chk1(hi_cnt >= RC - 3 && hi_cnt <= RC + 3, 1'b1);
        wr_sw(USBMC_ADDR_CTRL, 8'h08);
        chk1(engine_clk_en, 1'b1);
        wr_sw(USBMC_ADDR_CTRL, 8'h02);
        chk1(pullup_on | engine_clk_en, 1'b0);
        wr_sw(USBMC_ADDR_CTRL, 8'h08);
        chk1(engine_active & ~|ptr, 1'b1);
        pullup_cfg <= 1'b0;
        repeat (2) @(posedge mclk);
        #1 chk1(pullup_on, 1'b0);
        print_verdict();
    end
endmodule : usbmc_bench
